// [design/upp_pkg.sv]
package upp_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned HOLD_MS = 30;
  localparam int unsigned HOLD_CYCLES = HOLD_MS * 1000 * CLK_MHZ;
  localparam int unsigned SYNC_STAGES = 2;

  // ==========================================================
  // fault cause bit positions
  localparam int unsigned CAUSE_W = 6;
  localparam int unsigned CAUSE_VBUS = 0;
  localparam int unsigned CAUSE_DP = 1;
  localparam int unsigned CAUSE_DN = 2;
  localparam int unsigned CAUSE_GND = 3;
  localparam int unsigned CAUSE_OC = 4;
  localparam int unsigned CAUSE_THERM = 5;

  // ==========================================================
  // interrupt status layout
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_FAULT = 0;
  localparam int unsigned IRQ_THERM = 1;
  localparam int unsigned IRQ_CM = 2;

  // ==========================================================
  // register byte addresses
  localparam logic [11:0] REG_STATUS = 12'h000;
  localparam logic [11:0] REG_IRQ_STAT = 12'h004;
  localparam logic [11:0] REG_IRQ_EN = 12'h008;
  localparam logic [11:0] REG_IRQ_CLR = 12'h00C;
  localparam logic [11:0] REG_CTRL = 12'h010;

  // status word field positions
  localparam int unsigned ST_CLOSED = 0;
  localparam int unsigned ST_PROT = 1;
  localparam int unsigned ST_FALLBACK_EN = 2;
  localparam int unsigned ST_SPEED_LIM = 3;
  localparam int unsigned ST_CM = 4;
  localparam int unsigned ST_CAUSE = 8;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int unsigned CTRL_FORCE_OPEN = 0;

  typedef enum logic [1:0] {
    UPP_OPEN_T_UNUSED
  } upp_dummy_t;
endpackage : upp_pkg

// [design/upp_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module upp_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  // ==========================================================
  // two-stage synchroniser; first stage feeds only the second
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule : upp_sync
`default_nettype wire

// [design/upp_timer.sv]
`timescale 1ns/10ps
`default_nettype none
module upp_timer #(
  parameter int unsigned COUNT = 6000000
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_start,
  output logic o_done
);
  // ==========================================================
  // one-shot down counter; i_start reloads it
  localparam int unsigned CW = $clog2(COUNT + 1);
  logic [CW-1:0] cnt_q;
  logic run_q;

  initial begin
    if (COUNT < 1) $error("upp_timer: COUNT must be at least 1");
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (i_start) begin
      cnt_q <= CW'(COUNT - 1);
      run_q <= 1'b1;
    end else if (run_q && cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign o_done = run_q && (cnt_q == '0) && !i_start;
endmodule : upp_timer
`default_nettype wire

// [design/upp_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
module upp_ctrl #(
  parameter int unsigned HOLD_CYCLES = upp_pkg::HOLD_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // supply power-good, comparator and detector results (async)
  input wire logic i_supply_ok,
  input wire logic i_bus_power_fault,
  input wire logic i_data_plus_fault,
  input wire logic i_data_minus_fault,
  input wire logic i_connector_ground_fault,
  input wire logic i_ground_sense_over,
  input wire logic i_ground_sense_under,
  input wire logic i_cm_window_out,
  input wire logic i_over_temp,
  // common_mode_flag_n pin, open drain
  input wire logic i_common_mode_flag_n,
  output logic o_common_mode_flag_n_oe,
  output logic o_common_mode_flag_n_out,
  // fault_flag_n pin, open drain
  output logic o_fault_flag_n_oe,
  output logic o_fault_flag_n_out,
  // switch enables
  output logic o_ground_gate_system_side,
  output logic o_ground_gate_connector_side,
  output logic o_power_gate_connector_side,
  output logic o_power_gate_system_side,
  output logic o_data_switch,
  output logic o_speed_limit,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_irq
);
  localparam int unsigned NIN = 10;

  initial begin
    if (HOLD_CYCLES < 1) $error("upp_ctrl: HOLD_CYCLES must be >= 1");
  end

  // ==========================================================
  // shared helpers
  function automatic logic rising(input logic cur, input logic prev);
    return cur && !prev;
  endfunction : rising

  function automatic logic reg_hit(input logic [11:0] addr,
      input logic [11:0] offset);
    return addr == offset;
  endfunction : reg_hit

  // ==========================================================
  // input synchronisation
  logic [NIN-1:0] raw;
  logic [NIN-1:0] syn;
  assign raw = {i_common_mode_flag_n, i_supply_ok, i_over_temp,
                i_cm_window_out, i_ground_sense_under,
                i_ground_sense_over, i_connector_ground_fault,
                i_data_minus_fault, i_data_plus_fault,
                i_bus_power_fault};

  upp_sync #(.WIDTH(NIN)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_async(raw),
    .o_sync(syn)
  );

  logic s_vbus;
  logic s_dp;
  logic s_dn;
  logic s_gnd;
  logic s_gs_over;
  logic s_gs_under;
  logic s_cm;
  logic s_therm;
  logic s_supply;
  logic s_flag_pin;
  // unpacked in the same order as raw, so no bit index can drift
  assign {s_flag_pin, s_supply, s_therm, s_cm, s_gs_under, s_gs_over,
          s_gnd, s_dn, s_dp, s_vbus} = syn;
  wire s_oc = s_gs_over | s_gs_under;

  // ==========================================================
  // fault classification
  logic [upp_pkg::CAUSE_W-1:0] cause;
  assign cause[upp_pkg::CAUSE_VBUS] = s_vbus;
  assign cause[upp_pkg::CAUSE_DP] = s_dp;
  assign cause[upp_pkg::CAUSE_DN] = s_dn;
  assign cause[upp_pkg::CAUSE_GND] = s_gnd;
  assign cause[upp_pkg::CAUSE_OC] = s_oc;
  assign cause[upp_pkg::CAUSE_THERM] = s_therm;

  wire volt_fault = s_vbus | s_dp | s_dn | s_gnd | s_oc;
  wire any_fault = volt_fault | s_therm;
  wire vbus_only = s_vbus && !(s_dp | s_dn | s_gnd | s_oc | s_therm);

  // ==========================================================
  // protection state machine
  typedef enum logic [1:0] {
    ST_OFF,
    ST_IDLE,
    ST_PROT,
    ST_HOLD
  } upp_state_t;

  upp_state_t state_q, state_d;
  logic restart_q, restart_d;
  logic force_open;
  logic timer_start;
  logic timer_done;

  upp_timer #(.COUNT(HOLD_CYCLES)) u_timer (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_start(timer_start),
    .o_done(timer_done)
  );

  // timer restarts on every protection entry; a fault that persists
  // keeps the machine in ST_PROT while the hold counts from entry, not
  // from its release; only for non-bus faults
  always_comb begin
    state_d = state_q;
    restart_d = restart_q;
    timer_start = 1'b0;
    unique case (state_q)
      ST_OFF: begin
        if (s_supply) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (any_fault || force_open) begin
          state_d = ST_PROT;
          timer_start = 1'b1;
          restart_d = vbus_only;
        end
      end
      ST_PROT: begin
        if (!vbus_only && any_fault) begin
          restart_d = 1'b0;
        end
        if (restart_q) begin
          // bus-only fault: retry on interval regardless
          if (timer_done) begin
            state_d = ST_IDLE;
          end
        end else if (!any_fault) begin
          if (timer_done) begin
            state_d = ST_IDLE;
          end else begin
            state_d = ST_HOLD;
          end
        end
      end
      ST_HOLD: begin
        if (any_fault) begin
          state_d = ST_PROT;
          restart_d = vbus_only;
          timer_start = 1'b1;
        end else if (timer_done) begin
          state_d = ST_IDLE;
        end
      end
    endcase
    if (!s_supply) begin
      state_d = ST_OFF;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_q <= ST_OFF;
      restart_q <= 1'b0;
    end else begin
      state_q <= state_d;
      restart_q <= restart_d;
    end
  end

  // switches close only in idle with no fault input active and no force open
  wire close_d = (state_d == ST_IDLE) && !any_fault && !force_open;

  // ==========================================================
  // power-up strap capture of fallback enable
  logic strap_done_q;
  logic fallback_en_q;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      strap_done_q <= 1'b0;
      fallback_en_q <= 1'b0;
    end else if (!s_supply) begin
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      // released pin reads pull-up level; sampled once per power-up
      strap_done_q <= 1'b1;
      fallback_en_q <= s_flag_pin;
    end
  end

  wire speed_lim_d = fallback_en_q && s_cm && strap_done_q;

  // ==========================================================
  // outputs
  logic closed_q;
  logic speed_q;
  logic cm_oe_q;
  logic flt_oe_q;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      closed_q <= 1'b0;
      speed_q <= 1'b0;
      cm_oe_q <= 1'b0;
      flt_oe_q <= 1'b0;
    end else begin
      closed_q <= close_d;
      speed_q <= speed_lim_d;
      // pin stays released until strap has been taken
      cm_oe_q <= strap_done_q && s_cm;
      flt_oe_q <= s_supply && volt_fault;
    end
  end

  // all gates share one flop so the paths can never disagree
  assign o_ground_gate_system_side = closed_q;
  assign o_ground_gate_connector_side = closed_q;
  assign o_power_gate_connector_side = closed_q;
  assign o_power_gate_system_side = closed_q;
  assign o_data_switch = closed_q;
  assign o_speed_limit = speed_q;
  assign o_common_mode_flag_n_oe = cm_oe_q;
  assign o_common_mode_flag_n_out = 1'b0;
  assign o_fault_flag_n_oe = flt_oe_q;
  assign o_fault_flag_n_out = 1'b0;

  // ==========================================================
  // interrupts
  logic [upp_pkg::IRQ_W-1:0] irq_stat_q;
  logic [upp_pkg::IRQ_W-1:0] irq_en_q;
  logic [upp_pkg::IRQ_W-1:0] ev;
  logic flt_prev_q;
  logic therm_prev_q;
  logic cm_prev_q;
  logic irq_q;
  logic ctrl_q;

  assign ev[upp_pkg::IRQ_FAULT] = rising(volt_fault, flt_prev_q);
  assign ev[upp_pkg::IRQ_THERM] = rising(s_therm, therm_prev_q);
  assign ev[upp_pkg::IRQ_CM] = rising(speed_lim_d, cm_prev_q);

  // ==========================================================
  // APB slave, zero wait states
  wire acc = i_psel && i_penable;
  wire wr = acc && i_pwrite;
  wire a_stat = reg_hit(i_paddr, upp_pkg::REG_STATUS);
  wire a_ist = reg_hit(i_paddr, upp_pkg::REG_IRQ_STAT);
  wire a_ien = reg_hit(i_paddr, upp_pkg::REG_IRQ_EN);
  wire a_iclr = reg_hit(i_paddr, upp_pkg::REG_IRQ_CLR);
  wire a_ctrl = reg_hit(i_paddr, upp_pkg::REG_CTRL);
  // writes to read-only or unmapped words are dropped
  wire mapped = a_stat | a_ist | a_ien | a_iclr | a_ctrl;
  wire [upp_pkg::IRQ_W-1:0] clr =
    (wr && a_iclr) ? i_pwdata[upp_pkg::IRQ_W-1:0] : '0;
  // set wins over a clear in the same cycle
  wire [upp_pkg::IRQ_W-1:0] irq_stat_d = (irq_stat_q & ~clr) | ev;
  assign force_open = ctrl_q;

  logic [31:0] status_w;
  always_comb begin
    status_w = '0;
    status_w[upp_pkg::ST_CLOSED] = closed_q;
    status_w[upp_pkg::ST_PROT] = state_q != ST_IDLE;
    status_w[upp_pkg::ST_FALLBACK_EN] = fallback_en_q;
    status_w[upp_pkg::ST_SPEED_LIM] = speed_q;
    status_w[upp_pkg::ST_CM] = s_cm;
    status_w[upp_pkg::ST_CAUSE +: upp_pkg::CAUSE_W] = cause;
  end

  wire [31:0] rdata_d =
    a_stat ? status_w :
    a_ist ? 32'(irq_stat_q) :
    a_ien ? 32'(irq_en_q) :
    a_ctrl ? 32'(ctrl_q) : 32'h0;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      irq_stat_q <= '0;
      irq_en_q <= '0;
      flt_prev_q <= 1'b0;
      therm_prev_q <= 1'b0;
      cm_prev_q <= 1'b0;
      ctrl_q <= upp_pkg::CTRL_RESET[upp_pkg::CTRL_FORCE_OPEN];
      irq_q <= 1'b0;
      o_prdata <= 32'h0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      flt_prev_q <= volt_fault;
      therm_prev_q <= s_therm;
      cm_prev_q <= speed_lim_d;
      irq_stat_q <= irq_stat_d;
      irq_q <= |(irq_stat_d & irq_en_q);
      if (wr && a_ien) begin
        irq_en_q <= i_pwdata[upp_pkg::IRQ_W-1:0];
      end
      if (wr && a_ctrl) begin
        ctrl_q <= i_pwdata[upp_pkg::CTRL_FORCE_OPEN];
      end
      o_pready <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && !mapped;
      o_prdata <= (i_psel && !i_penable && !i_pwrite) ? rdata_d : 32'h0;
    end
  end

  assign o_irq = irq_q;
endmodule : upp_ctrl
`default_nettype wire

// [tb/upp_pin_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========
// open-drain flag pins as the board sees them
module upp_pin_model (
  input wire logic i_pullup_fitted,
  input wire logic i_cm_oe,
  input wire logic i_fault_oe,
  output logic o_cm_pin,
  output logic o_fault_pin
);
  // strap without pull-up reads low, so no floating level to guess
  assign o_cm_pin = i_cm_oe ? 1'h0 : i_pullup_fitted;
  assign o_fault_pin = !i_fault_oe;
endmodule : upp_pin_model
`default_nettype wire

// [tb/upp_ctrl_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========
// protection checker
module upp_ctrl_monitor #(
  parameter int unsigned HOLD_CYCLES = 20
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_supply_ok,
  input wire logic i_bus_power_fault,
  input wire logic i_data_plus_fault,
  input wire logic i_data_minus_fault,
  input wire logic i_connector_ground_fault,
  input wire logic i_ground_sense_over,
  input wire logic i_ground_sense_under,
  input wire logic i_cm_window_out,
  input wire logic i_over_temp,
  input wire logic i_common_mode_flag_n_oe,
  input wire logic i_fault_flag_n_oe,
  input wire logic i_ground_gate_system_side,
  input wire logic i_ground_gate_connector_side,
  input wire logic i_power_gate_connector_side,
  input wire logic i_power_gate_system_side,
  input wire logic i_data_switch,
  input wire logic i_speed_limit
);
  logic any_v;
  logic any_f;
  logic [31:0] open_cnt_q;
  assign any_v = i_bus_power_fault | i_data_plus_fault | i_data_minus_fault
    | i_connector_ground_fault | i_ground_sense_over | i_ground_sense_under;
  assign any_f = any_v | i_over_temp;
  // starts saturated so the first close after reset is not judged
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) open_cnt_q <= 32'hFFFF_FFFF;
    else if (i_data_switch) open_cnt_q <= 32'h0;
    else if (open_cnt_q != 32'hFFFF_FFFF) open_cnt_q <= open_cnt_q + 32'h1;
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  paths_equal_a: assert property (
    i_ground_gate_system_side == i_data_switch
    && i_ground_gate_connector_side == i_data_switch
    && i_power_gate_connector_side == i_data_switch
    && i_power_gate_system_side == i_data_switch)
    else $error("switch paths disagree");
  fault_opens_a: assert property (
    $rose(any_f) |-> ##[1:4] !i_data_switch)
    else $error("fault did not open paths");
  fault_held_a: assert property (
    any_f [*4] |-> !i_data_switch) else $error("closed during fault");
  no_supply_a: assert property (
    !i_supply_ok [*4] |-> !i_data_switch) else $error("closed unpowered");
  hold_time_a: assert property (
    $rose(i_data_switch) |-> open_cnt_q >= HOLD_CYCLES - 1)
    else $error("reclosed before hold time");
  flag_on_a: assert property (
    any_v [*4] |-> i_fault_flag_n_oe) else $error("fault flag not low");
  flag_off_a: assert property (
    !any_v [*4] |-> !i_fault_flag_n_oe) else $error("fault flag stuck");
  cm_flag_a: assert property (
    (i_cm_window_out && i_supply_ok) [*6] |-> i_common_mode_flag_n_oe)
    else $error("common mode flag not low");
  speed_off_a: assert property (
    !i_cm_window_out [*4] |-> !i_speed_limit) else $error("speed limited");
  cover property ($rose(i_data_switch));
  cover property ($fell(i_data_switch));
  cover property ($rose(i_speed_limit));
endmodule : upp_ctrl_monitor
bind upp_ctrl upp_ctrl_monitor #(.HOLD_CYCLES(HOLD_CYCLES)) mon_i (
  .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_supply_ok(i_supply_ok),
  .i_bus_power_fault(i_bus_power_fault),
  .i_data_plus_fault(i_data_plus_fault),
  .i_data_minus_fault(i_data_minus_fault),
  .i_connector_ground_fault(i_connector_ground_fault),
  .i_ground_sense_over(i_ground_sense_over),
  .i_ground_sense_under(i_ground_sense_under),
  .i_cm_window_out(i_cm_window_out), .i_over_temp(i_over_temp),
  .i_common_mode_flag_n_oe(o_common_mode_flag_n_oe),
  .i_fault_flag_n_oe(o_fault_flag_n_oe),
  .i_ground_gate_system_side(o_ground_gate_system_side),
  .i_ground_gate_connector_side(o_ground_gate_connector_side),
  .i_power_gate_connector_side(o_power_gate_connector_side),
  .i_power_gate_system_side(o_power_gate_system_side),
  .i_data_switch(o_data_switch), .i_speed_limit(o_speed_limit));
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int HOLD = 20;
  logic clk, rst, sup, cm, pull, psel, pen, pwr, rdy, err, sw, lim, irq;
  logic cm_oe, f_oe, cm_pin, f_pin;
  logic [6:0] flt;
  logic [3:0] g;
  logic [11:0] pa;
  logic [31:0] pwd, prd;
  int num_errors = 0;
  int checks_done = 0;
  upp_ctrl #(.HOLD_CYCLES(HOLD)) upp_ctrl_i (
    .i_ref_clk(clk), .i_reset(rst), .i_supply_ok(sup),
    .i_bus_power_fault(flt[0]), .i_data_plus_fault(flt[1]),
    .i_data_minus_fault(flt[2]), .i_connector_ground_fault(flt[3]),
    .i_ground_sense_over(flt[4]), .i_ground_sense_under(flt[5]),
    .i_over_temp(flt[6]), .i_cm_window_out(cm),
    .i_common_mode_flag_n(cm_pin), .o_common_mode_flag_n_oe(cm_oe),
    .o_common_mode_flag_n_out(), .o_fault_flag_n_oe(f_oe),
    .o_fault_flag_n_out(), .o_ground_gate_system_side(g[0]),
    .o_ground_gate_connector_side(g[1]),
    .o_power_gate_connector_side(g[2]),
    .o_power_gate_system_side(g[3]), .o_data_switch(sw),
    .o_speed_limit(lim), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy),
    .o_pslverr(err), .o_irq(irq));
  upp_pin_model upp_pin_model_i (.i_pullup_fitted(pull), .i_cm_oe(cm_oe),
    .i_fault_oe(f_oe), .o_cm_pin(cm_pin), .o_fault_pin(f_pin));
  // ==========
  // helpers
  function automatic logic [5:0] exp_cause(input logic [6:0] p);
    logic [5:0] c;
    c = 6'h0;
    c[upp_pkg::CAUSE_VBUS] = p[0];
    c[upp_pkg::CAUSE_DP] = p[1];
    c[upp_pkg::CAUSE_DN] = p[2];
    c[upp_pkg::CAUSE_GND] = p[3];
    c[upp_pkg::CAUSE_OC] = p[4] | p[5];
    c[upp_pkg::CAUSE_THERM] = p[6];
    return c;
  endfunction : exp_cause
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] y);
    checks_done++;
    if (y !== x) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, x, y);
    end
  endtask : chk
  task automatic chk1(input string n, input logic x, input logic y);
    chk(n, {31'h0, x}, {31'h0, y});
  endtask : chk1
  task automatic wait_sw(input logic v, input int lim);
    for (int n = 0; n < lim && sw !== v; n++) @(posedge clk);
  endtask : wait_sw
  // called just after a rising edge; holds the request until pready
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    psel <= 1'h1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'h1;
    @(posedge clk);
    while (rdy !== 1'h1) begin
      @(posedge clk);
    end
    q = prd;
    e = err;
    psel <= 1'h0;
    pen <= 1'h0;
    @(posedge clk);
  endtask : apb
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  // ==========
  // stimulus
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #250000;
    num_errors++;
    summarize();
  end
  initial begin
    logic [31:0] r;
    logic e;
    logic [6:0] p;
    {rst, pull} = 2'h3;
    {sup, cm, psel, pen, pwr} = 5'h0;
    flt = 7'h0;
    pa = 12'h0;
    pwd = 32'h0;
    void'($urandom(13693));
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    repeat (4) @(posedge clk);
    chk1("off", 1'h0, sw);
    sup <= 1'h1;
    wait_sw(1'h1, 100);
    chk("paths", 32'hF, {28'h0, g});
    apb(1'h0, upp_pkg::REG_STATUS, 32'h0, r, e);
    chk1("fallback", 1'h1, r[upp_pkg::ST_FALLBACK_EN]);
    for (int i = 0; i < 7; i++) begin
      flt <= 7'h1 << i;
      wait_sw(1'h0, 8);
      chk("opened", 32'h0, {28'h0, g});
      repeat (2 + $urandom % 4) @(posedge clk);
      chk1("fault_pin", i == 6, f_pin);
      apb(1'h0, upp_pkg::REG_STATUS, 32'h0, r, e);
      chk("cause", {26'h0, exp_cause(7'h1 << i)}, {26'h0, r[13:8]});
      flt <= 7'h0;
      wait_sw(1'h1, 2 * HOLD);
      chk1("reclosed", 1'h1, sw);
    end
    repeat (4) begin
      p = 7'($urandom_range(127, 1));
      flt <= p;
      wait_sw(1'h0, 8);
      chk1("rand_open", 1'h0, sw);
      repeat (4) @(posedge clk);
      chk1("rand_pin", ~|p[5:0], f_pin);
      apb(1'h0, upp_pkg::REG_STATUS, 32'h0, r, e);
      chk("rand_cause", {26'h0, exp_cause(p)}, {26'h0, r[13:8]});
      flt <= 7'h0;
      wait_sw(1'h1, 2 * HOLD);
      chk1("rand_close", 1'h1, sw);
    end
    $display("fault tests done");
    apb(1'h0, upp_pkg::REG_IRQ_STAT, 32'h0, r, e);
    chk("irq_stat", 32'h3, r);
    apb(1'h1, upp_pkg::REG_IRQ_EN, 32'h1, r, e);
    repeat (2) @(posedge clk);
    chk1("irq_on", 1'h1, irq);
    apb(1'h1, upp_pkg::REG_IRQ_EN, 32'h0, r, e);
    repeat (2) @(posedge clk);
    chk1("irq_mask", 1'h0, irq);
    apb(1'h1, upp_pkg::REG_IRQ_CLR, 32'h3, r, e);
    apb(1'h0, upp_pkg::REG_IRQ_STAT, 32'h0, r, e);
    chk("irq_clr", 32'h0, r);
    apb(1'h0, 12'h020, 32'h0, r, e);
    chk("unmapped", 32'h1, {r[30:0], e});
    apb(1'h1, upp_pkg::REG_CTRL, 32'h1, r, e);
    wait_sw(1'h0, 8);
    chk1("forced", 1'h0, sw);
    apb(1'h1, upp_pkg::REG_CTRL, 32'h0, r, e);
    wait_sw(1'h1, 2 * HOLD);
    chk1("released", 1'h1, sw);
    $display("register tests done");
    cm <= 1'h1;
    repeat (8) @(posedge clk);
    chk("cm_on", 32'h3, {30'h0, lim, !cm_pin});
    apb(1'h0, upp_pkg::REG_IRQ_STAT, 32'h0, r, e);
    chk("irq_cm", 32'h1 << upp_pkg::IRQ_CM, r);
    cm <= 1'h0;
    repeat (8) @(posedge clk);
    chk("cm_off", 32'h0, {30'h0, lim, !cm_pin});
    sup <= 1'h0;
    pull <= 1'h0;
    wait_sw(1'h0, 8);
    chk1("unpowered", 1'h0, sw);
    repeat (2 * HOLD) @(posedge clk);
    sup <= 1'h1;
    wait_sw(1'h1, 100);
    pull <= 1'h1;
    cm <= 1'h1;
    repeat (8) @(posedge clk);
    chk("no_limit", 32'h1, {30'h0, lim, !cm_pin});
    $display("strap tests done");
    summarize();
  end
endmodule : testbench
`default_nettype wire
